/* core/fdsl_top.sv */
// Floppy drive support logic: clock division, data separator, drive ready
// generator, spindle timing, step pulses, write serialiser and drive pins.
// Assumes the 4 MHz board clock and all drive inputs arrive asynchronously.
//
// How it works
// - Divide 4 MHz by two for the controller, and by 256 for the ready tick.
// - Separator counter at 2 MHz raises the window once, 5 us after the last read pulse.
// - Every raw read pulse clears separator counters, holding the window low.
// - A zero data bit sends no pulse, so the window rises 5 us later.
// - Window held until next pulse's falling edge; suppressed after the stream ends.
// - Ready counter of 14 stages on the slow tick; bit twelve high at 4096.
// - Each index pulse from a selected drive clears the ready counter.
// - Index before 4096 clocks counter bit twelve, still low, into that drive's ready flop.
// - Ready holds while index stays timely; deselection sets the flop, not ready.
// - Signals between board and drives are active low unless said otherwise.
// - Each select line directly picks one of at most two drives.
// - Motor runs on a motor request with a select; transfers wait 250 ms after motor start.
// - Motor stops after 2 s or more without a data transfer.
// - Direction low steps toward centre, high steps toward the edge.
// - Each step request gives one negative double pulse, moving one track.
// - Write gate low enables writing; high enables reading.
// - Bytes are serialised with clock pulses, inverted, onto the write line.
// - Surface pick high selects the left surface, low the right one.
`include "fdsl_regs.svh"
`default_nettype none

module fdsl_top #(
    parameter int TICK_US      = `FDSL_TICK_US,
    parameter int SPIN_UP_TICKS = (`FDSL_SPIN_UP_MS * `FDSL_US_PER_MS + TICK_US - 1) / TICK_US,
    parameter int IDLE_TICKS    = (`FDSL_IDLE_MS * `FDSL_US_PER_MS + TICK_US - 1) / TICK_US
) (
    input  wire logic       CORE_CLK,
    input  wire logic       NRST,
    input  wire logic       CORE_CE,
    input  wire logic       BOARD_4M,
    output logic            CTRL_CLK_2M,
    input  wire logic [1:0] CTRL_SEL,
    input  wire logic       CTRL_MOTOR_REQ,
    input  wire logic       CTRL_XFER_ACTIVE,
    output logic            CTRL_XFER_OK,
    input  wire logic       CTRL_TOWARD_CENTRE,
    input  wire logic       CTRL_STEP_REQ,
    input  wire logic       CTRL_WRITE_REQ,
    input  wire logic       CTRL_SURFACE_LEFT,
    input  wire logic [7:0] CTRL_WR_BYTE,
    input  wire logic       CTRL_WR_VALID,
    output logic            CTRL_WR_READY,
    output logic            BIT_WINDOW_PULSE,
    output logic            DRIVE_A_OK_N,
    output logic            DRIVE_B_OK_N,
    output logic            CTRL_HOME_TRACK_N,
    output logic            CTRL_REVOLUTION_MARK_N,
    output logic            CTRL_RAW_READ_N,
    output logic            CTRL_WRITE_LOCKED_N,
    output logic            DRIVE_PICK_A_N,
    output logic            DRIVE_PICK_B_N,
    output logic            SPINDLE_RUN_N,
    output logic            HEAD_TOWARD_CENTRE,
    output logic            HEAD_TRACK_PULSE_N,
    output logic            WRITE_GATE_N,
    output logic            SERIAL_WRITE_LINE_N,
    output logic            SURFACE_PICK,
    input  wire logic       HOME_TRACK_N,
    input  wire logic       REVOLUTION_MARK_N,
    input  wire logic       RAW_READ_LINE_N,
    input  wire logic       WRITE_LOCKED_N
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [`FDSL_SYNC_W-1:0] meta_q;
    logic [`FDSL_SYNC_W-1:0] sync_q;
    logic [`FDSL_SYNC_W-1:0] last_q;

    wire [`FDSL_SYNC_W-1:0] async_in = {WRITE_LOCKED_N, RAW_READ_LINE_N, REVOLUTION_MARK_N,
                                        HOME_TRACK_N, BOARD_4M};

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            meta_q <= {`FDSL_SYNC_W{1'b1}};
            sync_q <= {`FDSL_SYNC_W{1'b1}};
            last_q <= {`FDSL_SYNC_W{1'b1}};
        end else if (CORE_CE) begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    wire b4_rise   = CORE_CE && sync_q[`FDSL_SYNC_B4M] && !last_q[`FDSL_SYNC_B4M];
    wire index_hit = CORE_CE && !sync_q[`FDSL_SYNC_REV] && last_q[`FDSL_SYNC_REV];
    wire raw_fall  = CORE_CE && !sync_q[`FDSL_SYNC_RAW] && last_q[`FDSL_SYNC_RAW];

    // ------------------------------------------------------------------
    // Clock division
    // ------------------------------------------------------------------
    logic                  half_q;
    logic [`FDSL_DIV_W-1:0] div_q;

    wire sep_tick  = b4_rise && half_q;
    wire slow_tick = b4_rise && (div_q == `FDSL_DIV_LAST);

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            half_q <= 1'b0;
            div_q  <= {`FDSL_DIV_W{1'b0}};
        end else if (b4_rise) begin
            half_q <= !half_q;
            div_q  <= div_q + {{(`FDSL_DIV_W-1){1'b0}}, 1'b1};
        end
    end

    assign CTRL_CLK_2M = half_q;

    // ------------------------------------------------------------------
    // Data separator
    // ------------------------------------------------------------------
    logic [`FDSL_SEP_W-1:0] sep_q;
    logic                   stream_q;
    logic                   window_q;

    wire sep_hit  = sep_q[`FDSL_SEP_DIV4_BIT] && sep_q[`FDSL_SEP_DIV16_BIT];
    wire sep_done = (sep_q == `FDSL_SEP_END);

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sep_q    <= `FDSL_SEP_ZERO;
            stream_q <= 1'b0;
            window_q <= 1'b0;
        end else if (CORE_CE) begin
            if (raw_fall) begin
                sep_q    <= `FDSL_SEP_ZERO;
                stream_q <= 1'b1;
                window_q <= 1'b0;
            end else if (sep_tick && !sep_done) begin
                sep_q <= sep_q + {{(`FDSL_SEP_W-1){1'b0}}, 1'b1};
            end
            if (!raw_fall && sep_hit && stream_q) begin
                window_q <= 1'b1;
            end
            if (!raw_fall && sep_done) begin
                stream_q <= 1'b0;
                window_q <= 1'b0;
            end
        end
    end

    assign BIT_WINDOW_PULSE = window_q;

    // ------------------------------------------------------------------
    // Drive ready generator
    // ------------------------------------------------------------------
    logic [`FDSL_RDY_W-1:0] rdy_cnt_q;
    logic [1:0]             ok_n_q;

    wire counter_bit_twelve = rdy_cnt_q[`FDSL_RDY_BIT];
    wire any_sel            = CTRL_SEL[0] || CTRL_SEL[1];

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            rdy_cnt_q <= `FDSL_RDY_RST;
        end else if (CORE_CE) begin
            if (index_hit && any_sel) begin
                rdy_cnt_q <= `FDSL_RDY_ZERO;
            end else if (slow_tick && !counter_bit_twelve) begin
                rdy_cnt_q <= rdy_cnt_q + {{(`FDSL_RDY_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // One ready flop per drive; the count stops once bit twelve is high so
    // a wrap can never fake a timely index.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ready
            always_ff @(posedge CORE_CLK) begin
                if (!NRST) begin
                    ok_n_q[gi] <= 1'b1;
                end else if (CORE_CE) begin
                    if (!CTRL_SEL[gi]) begin
                        ok_n_q[gi] <= 1'b1;
                    end else if (index_hit) begin
                        ok_n_q[gi] <= counter_bit_twelve;
                    end
                end
            end
        end
    endgenerate

    assign DRIVE_A_OK_N = ok_n_q[0];
    assign DRIVE_B_OK_N = ok_n_q[1];

    // ------------------------------------------------------------------
    // Spindle timing
    // ------------------------------------------------------------------
    logic [`FDSL_TMR_W-1:0] spin_q;
    logic [`FDSL_TMR_W-1:0] idle_q;
    logic                   run_q;
    logic                   motor_req_q;

    wire motor_start = CTRL_MOTOR_REQ && !motor_req_q;
    wire spun_up     = (spin_q == SPIN_UP_TICKS[`FDSL_TMR_W-1:0]);
    wire idle_out    = (idle_q == IDLE_TICKS[`FDSL_TMR_W-1:0]);

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            run_q       <= 1'b0;
            motor_req_q <= 1'b0;
            spin_q      <= {`FDSL_TMR_W{1'b0}};
            idle_q      <= {`FDSL_TMR_W{1'b0}};
        end else if (CORE_CE) begin
            motor_req_q <= CTRL_MOTOR_REQ;
            if (!CTRL_MOTOR_REQ || !any_sel || idle_out) begin
                run_q <= 1'b0;
            end else if (motor_start || CTRL_XFER_ACTIVE) begin
                run_q <= 1'b1;
            end
            if (!run_q) begin
                spin_q <= {`FDSL_TMR_W{1'b0}};
            end else if (slow_tick && !spun_up) begin
                spin_q <= spin_q + {{(`FDSL_TMR_W-1){1'b0}}, 1'b1};
            end
            if (!run_q || CTRL_XFER_ACTIVE) begin
                idle_q <= {`FDSL_TMR_W{1'b0}};
            end else if (slow_tick && !idle_out) begin
                idle_q <= idle_q + {{(`FDSL_TMR_W-1){1'b0}}, 1'b1};
            end
        end
    end

    wire xfer_ok = run_q && spun_up;
    assign CTRL_XFER_OK = xfer_ok;

    // ------------------------------------------------------------------
    // Step double pulse
    // ------------------------------------------------------------------
    fdsl_pkg::fdsl_step_e   step_q;
    logic [`FDSL_STEP_W-1:0] step_cnt_q;

    wire step_slot = sep_tick && (step_cnt_q == `FDSL_STEP_LAST);

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            step_q     <= fdsl_pkg::ST_IDLE;
            step_cnt_q <= {`FDSL_STEP_W{1'b0}};
        end else if (CORE_CE) begin
            if (sep_tick) begin
                step_cnt_q <= step_cnt_q + {{(`FDSL_STEP_W-1){1'b0}}, 1'b1};
            end
            case (step_q)
                fdsl_pkg::ST_IDLE: begin
                    if (CTRL_STEP_REQ) begin
                        step_q     <= fdsl_pkg::ST_LOW1;
                        step_cnt_q <= {`FDSL_STEP_W{1'b0}};
                    end
                end
                fdsl_pkg::ST_LOW1: begin
                    if (step_slot) step_q <= fdsl_pkg::ST_GAP;
                end
                fdsl_pkg::ST_GAP: begin
                    if (step_slot) step_q <= fdsl_pkg::ST_LOW2;
                end
                fdsl_pkg::ST_LOW2: begin
                    if (step_slot) step_q <= fdsl_pkg::ST_IDLE;
                end
                default: step_q <= fdsl_pkg::ST_IDLE;
            endcase
        end
    end

    wire step_low = (step_q == fdsl_pkg::ST_LOW1) || (step_q == fdsl_pkg::ST_LOW2);

    // ------------------------------------------------------------------
    // Write serialiser
    // ------------------------------------------------------------------
    wire write_on = CTRL_WRITE_REQ && xfer_ok && sync_q[`FDSL_SYNC_WLOCK];
    logic ser_line_n;

    fdsl_fm_writer u_writer (
        .clk        (CORE_CLK),
        .rst_n      (NRST),
        .ce         (CORE_CE),
        .tick       (sep_tick),
        .enable     (write_on),
        .byte_in    (CTRL_WR_BYTE),
        .byte_valid (CTRL_WR_VALID),
        .byte_ready (CTRL_WR_READY),
        .line_n     (ser_line_n)
    );

    // ------------------------------------------------------------------
    // Drive-side and controller-side pins
    // ------------------------------------------------------------------
    logic [1:0] pick_n_q;
    logic       dir_q;
    logic       step_n_q;
    logic       gate_n_q;
    logic       surf_q;

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            pick_n_q <= 2'h3;
            dir_q    <= 1'b1;
            step_n_q <= 1'b1;
            gate_n_q <= 1'b1;
            surf_q   <= 1'b1;
        end else if (CORE_CE) begin
            pick_n_q <= ~CTRL_SEL;
            dir_q    <= !CTRL_TOWARD_CENTRE;
            step_n_q <= !step_low;
            gate_n_q <= !write_on;
            surf_q   <= CTRL_SURFACE_LEFT;
        end
    end

    // Active-low levels toward the drives; the active-low drive inputs are
    // passed on to the controller after synchronising.
    assign DRIVE_PICK_A_N         = pick_n_q[0];
    assign DRIVE_PICK_B_N         = pick_n_q[1];
    assign SPINDLE_RUN_N          = !run_q;
    assign HEAD_TOWARD_CENTRE     = dir_q;
    assign HEAD_TRACK_PULSE_N     = step_n_q;
    assign WRITE_GATE_N           = gate_n_q;
    assign SERIAL_WRITE_LINE_N    = ser_line_n;
    assign SURFACE_PICK           = surf_q;
    assign CTRL_HOME_TRACK_N      = sync_q[`FDSL_SYNC_HOME];
    assign CTRL_REVOLUTION_MARK_N = sync_q[`FDSL_SYNC_REV];
    assign CTRL_RAW_READ_N        = sync_q[`FDSL_SYNC_RAW];
    assign CTRL_WRITE_LOCKED_N    = sync_q[`FDSL_SYNC_WLOCK];

endmodule : fdsl_top

`default_nettype wire

/* shared/fdsl_regs.svh */
// Constants for the floppy drive support logic: divider widths, separator
// counts, ready counter layout and the spindle timing figures.
// Assumes a 4 MHz board clock arriving as a pin and a 15.625 kHz slow tick.
`ifndef FDSL_REGS_SVH
`define FDSL_REGS_SVH

`define FDSL_SYNC_W        5
`define FDSL_SYNC_B4M      0
`define FDSL_SYNC_HOME     1
`define FDSL_SYNC_REV      2
`define FDSL_SYNC_RAW      3
`define FDSL_SYNC_WLOCK    4

`define FDSL_DIV_W         8
`define FDSL_DIV_LAST      8'hFF

`define FDSL_SEP_W         5
`define FDSL_SEP_DIV4_BIT  1
`define FDSL_SEP_DIV16_BIT 3
`define FDSL_SEP_END       5'h14
`define FDSL_SEP_ZERO      5'h00

`define FDSL_RDY_W         14
`define FDSL_RDY_BIT       12
`define FDSL_RDY_RST       14'h1000
`define FDSL_RDY_ZERO      14'h0000

`define FDSL_TICK_US       64
`define FDSL_SPIN_UP_MS    250
`define FDSL_IDLE_MS       2000
`define FDSL_US_PER_MS     1000
`define FDSL_TMR_W         16

`define FDSL_CELL_LAST     3'h7
`define FDSL_CELL_DATA     3'h4
`define FDSL_BIT_LAST      3'h7
`define FDSL_STEP_W        2
`define FDSL_STEP_LAST     2'h3

`endif

/* shared/fdsl_pkg.sv */
// Types shared by the floppy drive support logic modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package fdsl_pkg;

    typedef enum logic [0:0] {
        WR_IDLE  = 1'b0,
        WR_SHIFT = 1'b1
    } fdsl_wr_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOW1  = 2'b01,
        ST_GAP   = 2'b10,
        ST_LOW2  = 2'b11
    } fdsl_step_e;

endpackage : fdsl_pkg

`default_nettype wire

/* core/fdsl_fm_writer.sv */
// Write serialiser: turns one byte into clock and data cells on the write line.
// Assumes tick is a one-cycle 2 MHz enable from the same clock domain.
`include "fdsl_regs.svh"
`default_nettype none

module fdsl_fm_writer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic [7:0] byte_in,
    input  wire logic       byte_valid,
    output logic            byte_ready,
    output logic            line_n
);

    fdsl_pkg::fdsl_wr_e state_q;
    logic [7:0]         shreg_q;
    logic [2:0]         phase_q;
    logic [2:0]         bitn_q;
    logic               line_q;

    wire take      = ce && enable && byte_valid && (state_q == fdsl_pkg::WR_IDLE);
    wire cell_end  = tick && (phase_q == `FDSL_CELL_LAST);
    wire byte_end  = cell_end && (bitn_q == `FDSL_BIT_LAST);
    // A clock pulse opens every cell; a data pulse sits mid-cell for a one.
    wire pulse_now = (phase_q == 3'h0) || ((phase_q == `FDSL_CELL_DATA) && shreg_q[7]);

    assign byte_ready = enable && (state_q == fdsl_pkg::WR_IDLE);
    assign line_n     = line_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= fdsl_pkg::WR_IDLE;
            shreg_q <= 8'h00;
            phase_q <= 3'h0;
            bitn_q  <= 3'h0;
            line_q  <= 1'b1;
        end else if (ce) begin
            if (take) begin
                state_q <= fdsl_pkg::WR_SHIFT;
                shreg_q <= byte_in;
                phase_q <= 3'h0;
                bitn_q  <= 3'h0;
            end else if (state_q == fdsl_pkg::WR_SHIFT && tick) begin
                phase_q <= phase_q + 3'h1;
                if (cell_end) begin
                    shreg_q <= {shreg_q[6:0], 1'b0};
                    bitn_q  <= bitn_q + 3'h1;
                end
                if (byte_end || !enable) begin
                    state_q <= fdsl_pkg::WR_IDLE;
                end
            end
            // The line is sent inverted: a pulse drives it low.
            line_q <= !((state_q == fdsl_pkg::WR_SHIFT) && enable && pulse_now);
        end
    end

endmodule : fdsl_fm_writer

`default_nettype wire

/* test/fdsl_props.sv */
// Assertion checker for fdsl_top, attached by the bind statement at the foot.
// Assumes one clock domain with the synchronous active-low reset on NRST.
`default_nettype none

module fdsl_props (
    input wire logic       CORE_CLK,
    input wire logic       NRST,
    input wire logic [1:0] CTRL_SEL,
    input wire logic       CTRL_TOWARD_CENTRE,
    input wire logic       CTRL_CLK_2M,
    input wire logic       CTRL_XFER_OK,
    input wire logic       BIT_WINDOW_PULSE,
    input wire logic       DRIVE_A_OK_N,
    input wire logic       DRIVE_B_OK_N,
    input wire logic       CTRL_RAW_READ_N,
    input wire logic       CTRL_WRITE_LOCKED_N,
    input wire logic       SPINDLE_RUN_N,
    input wire logic       HEAD_TOWARD_CENTRE,
    input wire logic       HEAD_TRACK_PULSE_N,
    input wire logic       WRITE_GATE_N
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    property p_clk_div; $changed(CTRL_CLK_2M) |=> $stable(CTRL_CLK_2M); endproperty
    a_clk_div: assert property (p_clk_div) else $error("divider toggled twice");
    property p_dir;
        $stable(CTRL_TOWARD_CENTRE) && $past(NRST) |-> HEAD_TOWARD_CENTRE == !CTRL_TOWARD_CENTRE;
    endproperty
    a_dir: assert property (p_dir) else $error("direction level wrong");
    property p_desel_a; !CTRL_SEL[0] && !$past(CTRL_SEL[0]) && $past(NRST) |-> DRIVE_A_OK_N; endproperty
    a_desel_a: assert property (p_desel_a) else $error("deselected drive ready");
    property p_reset; $rose(NRST) |-> DRIVE_A_OK_N && DRIVE_B_OK_N && !BIT_WINDOW_PULSE; endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_spin; $fell(SPINDLE_RUN_N) |-> !CTRL_XFER_OK [*8]; endproperty
    a_spin: assert property (p_spin) else $error("transfer allowed at motor start");
    property p_raw_clear; $fell(CTRL_RAW_READ_N) |-> ##[1:3] !BIT_WINDOW_PULSE [*8]; endproperty
    a_raw_clear: assert property (p_raw_clear) else $error("window not cleared");
    property p_step; $fell(HEAD_TRACK_PULSE_N) |=> !HEAD_TRACK_PULSE_N [*4]; endproperty
    a_step: assert property (p_step) else $error("step pulse too short");
    property p_wprot; !CTRL_WRITE_LOCKED_N [*3] |-> WRITE_GATE_N; endproperty
    a_wprot: assert property (p_wprot) else $error("write gate on locked disc");
endmodule // fdsl_props

bind fdsl_top fdsl_props i_fdsl_props (.*);

`default_nettype wire

/* test/fdsl_drive_model.sv */
// Behavioural model of one drive on the chain, answering only while picked.
// Assumes the bench requests index and read pulses; released lines sit high.
`default_nettype none

module fdsl_drive_model (
    input  wire logic       clk,
    input  wire logic       pick_a_n,
    input  wire logic       pick_b_n,
    input  wire logic       outward,
    input  wire logic       step_n,
    input  wire logic       idx_req,
    input  wire logic       rd_req,
    input  wire logic       wp,
    output logic            home_n,
    output logic            idx_n,
    output logic            rd_n,
    output logic            wlock_n,
    output logic [7:0]      track = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       sel;
    logic       half    = 1'b0;
    logic       step_q  = 1'b1;
    logic [3:0] idx_cnt = 4'h0;
    logic [1:0] rd_cnt  = 2'h0;

    assign sel     = !(pick_a_n && pick_b_n);
    assign home_n  = !(sel && track == 8'h00);
    assign idx_n   = !(sel && idx_cnt != 4'h0);
    assign rd_n    = !(sel && rd_cnt != 2'h0);
    assign wlock_n = !(sel && wp);

    always @(posedge clk) begin
        step_q <= step_n;
        idx_cnt <= (idx_cnt != 4'h0) ? idx_cnt - 4'h1 : (idx_req ? 4'h8 : 4'h0);
        rd_cnt <= (rd_cnt != 2'h0) ? rd_cnt - 2'h1 : (rd_req ? 2'h3 : 2'h0);
        // The head moves once per pair of falling edges on the step line.
        if (sel && step_q && !step_n) begin
            half <= !half;
            if (half)
                track <= outward ? track - 8'h01 : track + 8'h01;
        end
    end
endmodule // fdsl_drive_model

`default_nettype wire

/* test/tb.sv */
// Self-checking bench for fdsl_top with the drive model on its drive pins.
// Assumes the checker binds itself and a fast board clock.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk     = 1'b0;
    logic       nrst    = 1'b0;
    logic       b4m     = 1'b0;
    logic [1:0] div     = 2'h0;
    logic [1:0] sel     = 2'h0;
    logic       mot     = 1'b0;
    logic       xact    = 1'b0;
    logic       tcen    = 1'b0;
    logic       stp     = 1'b0;
    logic       wreq    = 1'b0;
    logic       left    = 1'b0;
    logic [7:0] wbyte   = 8'h00;
    logic       wval    = 1'b0;
    logic       idx_req = 1'b0;
    logic       rd_req  = 1'b0;
    logic       wp      = 1'b0;
    logic       c2m, xok, wrdy, win, aok_n, bok_n, home_n, wl_n, pa_n, pb_n;
    logic       run_n, htc, step_n, wg_n, wd_n, sp, d_home, d_idx, d_rd, d_wl;
    logic [7:0] track;
    int         n_errors = 0;
    int         checks   = 0;
    int         cyc      = 0;

    fdsl_top #(.SPIN_UP_TICKS(4), .IDLE_TICKS(8)) i_fdsl_top (
        .CORE_CLK(clk), .NRST(nrst), .CORE_CE(1'b1), .BOARD_4M(b4m), .CTRL_CLK_2M(c2m),
        .CTRL_SEL(sel), .CTRL_MOTOR_REQ(mot), .CTRL_XFER_ACTIVE(xact), .CTRL_XFER_OK(xok),
        .CTRL_TOWARD_CENTRE(tcen), .CTRL_STEP_REQ(stp), .CTRL_WRITE_REQ(wreq),
        .CTRL_SURFACE_LEFT(left), .CTRL_WR_BYTE(wbyte), .CTRL_WR_VALID(wval),
        .CTRL_WR_READY(wrdy), .BIT_WINDOW_PULSE(win), .DRIVE_A_OK_N(aok_n),
        .DRIVE_B_OK_N(bok_n), .CTRL_HOME_TRACK_N(home_n), .CTRL_REVOLUTION_MARK_N(),
        .CTRL_RAW_READ_N(), .CTRL_WRITE_LOCKED_N(wl_n), .DRIVE_PICK_A_N(pa_n),
        .DRIVE_PICK_B_N(pb_n), .SPINDLE_RUN_N(run_n), .HEAD_TOWARD_CENTRE(htc),
        .HEAD_TRACK_PULSE_N(step_n), .WRITE_GATE_N(wg_n), .SERIAL_WRITE_LINE_N(wd_n),
        .SURFACE_PICK(sp), .HOME_TRACK_N(d_home), .REVOLUTION_MARK_N(d_idx),
        .RAW_READ_LINE_N(d_rd), .WRITE_LOCKED_N(d_wl)
    );

    fdsl_drive_model i_fdsl_drive_model (
        .clk(clk), .pick_a_n(pa_n), .pick_b_n(pb_n), .outward(htc), .step_n(step_n),
        .idx_req(idx_req), .rd_req(rd_req), .wp(wp), .home_n(d_home), .idx_n(d_idx),
        .rd_n(d_rd), .wlock_n(d_wl), .track(track)
    );

    always #4 clk = ~clk;

    // Board clock of eight core cycles: a slow tick is 2048 cycles, a separator tick 16.
    always @(posedge clk) begin
        div <= div + 2'h1;
        if (div == 2'h3)
            b4m <= ~b4m;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            $display("ERROR %0t run timed out", $time);
            report_and_stop;
        end
    end

    function automatic bit bad(input logic ok);
        checks++;
        return ok !== 1'b1;
    endfunction

    task automatic err(input string msg);
        n_errors++;
        $display("ERROR %0t %s", $time, msg);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input bit rd);
        @(posedge clk) {rd_req, idx_req} <= {rd, !rd};
        @(posedge clk) {rd_req, idx_req} <= 2'b00;
    endtask

    task automatic t_reset;
        wt(1);
        if (bad(aok_n === 1'b1 && bok_n === 1'b1 && win === 1'b0)) err("reset state");
        if (bad({pa_n, pb_n, run_n, step_n, wg_n, wd_n} === 6'h3F)) err("idle pins");
    endtask

    task automatic t_pins;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) {sel, tcen, left} <= {(i ? 2'h1 : 2'h2), i[0], i[0]};
            wt(3);
            if (bad({pa_n, pb_n} === (i ? 2'b01 : 2'b10))) err("drive pick");
            if (bad(htc === !i[0])) err("head direction");
            if (bad(sp === i[0])) err("surface pick");
        end
    endtask

    task automatic t_clkdiv;
        logic p;
        int   n;
        n = 0;
        wt(1);
        p = c2m;
        for (int i = 0; i < 256; i++) begin
            wt(1);
            if (c2m !== p)
                n++;
            p = c2m;
        end
        if (bad(n >= 31 && n <= 33)) err("controller clock rate");
    endtask

    task automatic t_sep;
        pulse(1'b1);
        wt(120);
        if (bad(win === 1'b0)) err("window early");
        wt(80);
        if (bad(win === 1'b1)) err("window missing");
        wt(80);
        if (bad(win === 1'b1)) err("window not held");
        pulse(1'b1);
        wt(8);
        if (bad(win === 1'b0)) err("window not cleared");
        wt(600);
        if (bad(win === 1'b0)) err("window after stream end");
    endtask

    task automatic t_ready;
        pulse(1'b0);
        wt(20);
        if (bad(aok_n === 1'b1)) err("ready on first index");
        for (int i = 0; i < 2; i++) begin
            pulse(1'b0);
            wt(20);
            if (bad(aok_n === 1'b0 && bok_n === 1'b1)) err("drive a ready");
        end
        @(posedge clk) sel <= 2'h2;
        wt(4);
        if (bad(aok_n === 1'b1)) err("ready after deselect");
        pulse(1'b0);
        pulse(1'b0);
        wt(20);
        if (bad(bok_n === 1'b0 && aok_n === 1'b1)) err("drive b ready");
        @(posedge clk) sel <= 2'h1;
        wt(4);
    endtask

    task automatic t_step;
        if (bad(home_n === 1'b0)) err("home track at start");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) tcen <= !i[0];
            wt(2);
            @(posedge clk) stp <= 1'b1;
            @(posedge clk) stp <= 1'b0;
            wt(400);
            if (bad(track === (i ? 8'h00 : 8'h01))) err("head track");
            if (bad(home_n === !i[0])) err("home track");
        end
    endtask

    task automatic t_spin;
        @(posedge clk) {mot, xact} <= 2'b11;
        wt(4);
        if (bad(run_n === 1'b0)) err("motor off");
        wt(5000);
        if (bad(xok === 1'b0)) err("transfer too early");
        for (int i = 0; i < 8000 && xok !== 1'b1; i++)
            wt(1);
        if (bad(xok === 1'b1)) err("transfer never allowed");
    endtask

    task automatic t_write;
        logic p;
        int   n;
        @(posedge clk) wreq <= 1'b1;
        wt(4);
        if (bad(wg_n === 1'b0)) err("write gate");
        @(posedge clk) {wbyte, wval} <= {8'hA5, 1'b1};
        #1;
        for (int i = 0; i < 50 && wrdy !== 1'b1; i++)
            wt(1);
        @(posedge clk) wval <= 1'b0;
        wt(1);
        if (bad(wrdy === 1'b0)) err("writer not busy");
        n = 0;
        p = 1'b1;
        for (int i = 0; i < 3000 && wrdy !== 1'b1; i++) begin
            wt(1);
            if (p === 1'b1 && wd_n === 1'b0)
                n++;
            p = wd_n;
        end
        if (bad(n == 12 && wd_n === 1'b1)) err("write pulse count");
        @(posedge clk) wp <= 1'b1;
        wt(8);
        if (bad(wl_n === 1'b0 && wg_n === 1'b1)) err("locked disc written");
        @(posedge clk) {wp, wreq} <= 2'b00;
    endtask

    task automatic t_idle;
        @(posedge clk) xact <= 1'b0;
        wt(12000);
        if (bad(run_n === 1'b0)) err("motor stopped early");
        for (int i = 0; i < 8000 && run_n !== 1'b1; i++)
            wt(1);
        if (bad(run_n === 1'b1 && xok === 1'b0)) err("motor still on");
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_pins;
        t_clkdiv;
        t_sep;
        t_ready;
        t_step;
        t_spin;
        t_write;
        t_idle;
        report_and_stop;
    end
endmodule // tb

`default_nettype wire
